/* File: hdl/bssp_core.sv */
// buffered synchronous serial port: buffer, shifter, clocking, flags
`timescale 1ns/10ps
module bssp_core (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      start_wr_in,
  input  wire logic                      stop_wr_in,
  input  wire logic                      ovr_clr_in,
  input  wire logic                      wait_clr_in,
  input  wire logic                      abort_clr_in,
  input  wire logic                      irq_clr_in,
  input  wire logic                      sol_wr_in,
  input  wire logic                      sol_val_in,
  input  wire logic                      buf_rd_in,
  input  wire logic                      buf_wr_in,
  input  wire logic [bssp_pkg::IDX_W-1:0] buf_addr_in,
  input  wire logic [7:0]                buf_wdata_in,
  output wire logic [7:0]                buf_rdata_out,
  input  wire logic [1:0]                mode_in,
  input  wire logic [2:0]                clk_sel_in,
  input  wire logic [1:0]                gap_sel_in,
  input  wire logic [bssp_pkg::IDX_W-1:0] first_idx_in,
  input  wire logic [bssp_pkg::IDX_W-1:0] last_idx_in,
  input  wire logic                      cs_en_in,
  input  wire logic                      strobe_en_in,
  input  wire logic                      open_drain_in,
  output wire logic                      start_busy_out,
  output wire logic                      overrun_out,
  output wire logic                      wait_out,
  output wire logic                      abort_out,
  output wire logic                      irq_req_out,
  output wire logic                      sol_out,
  input  wire logic                      sck_in,
  output wire logic                      sck_out,
  output wire logic                      sck_oe_out,
  input  wire logic                      si_in,
  output wire logic                      so_out,
  output wire logic                      so_oe_out,
  input  wire logic                      cs_n_in,
  output wire logic                      strobe_out
);
  import bssp_pkg::*;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  bssp_state_e state_reg;
  bssp_state_e state_next;

  logic [7:0]       mem [BUF_DEPTH];
  logic [IDX_W-1:0] idx_reg;
  logic [2:0]       bit_reg;
  logic [7:0]       sh_reg;
  logic [7:0]       rx_reg;
  logic [7:0]       rdata_reg;
  logic [7:0]       div_reg;
  logic [3:0]       gap_reg;
  logic             sck_reg;
  logic             so_reg;
  logic             sck_d_reg;
  logic             strobe_reg;
  logic             ovr_reg;
  logic             wait_reg;
  logic             abort_reg;
  logic             irq_reg;

  logic             sck_s;
  logic             cs_s;
  logic             si_s;

  // pins from outside pass the filtered synchroniser
  bssp_sync3 #(.INIT(1'b1)) u_sync_sck (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .d_in        (sck_in),
    .q_out       (sck_s)
  );
  bssp_sync3 #(.INIT(1'b1)) u_sync_cs (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .d_in        (cs_n_in),
    .q_out       (cs_s)
  );
  bssp_sync3 #(.INIT(1'b1)) u_sync_si (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .d_in        (si_in),
    .q_out       (si_s)
  );

  // decode of mode, clock and state
  wire       tx_en    = mode_in[MODE_TX_POS];
  wire       rx_en    = mode_in[MODE_RX_POS];
  wire       ext_clk  = (clk_sel_in == CKS_EXT);
  wire [7:0] half     = bssp_half(clk_sel_in);
  wire [3:0] gap_len  = bssp_gap(gap_sel_in);
  wire       busy     = (state_reg != ST_IDLE);
  wire       st_shift = (state_reg == ST_SHIFT);
  wire       st_gap   = (state_reg == ST_GAP);
  wire       xfer     = st_shift | st_gap;
  wire       cs_high  = cs_en_in & cs_s;

  // external clock edges, seen after the filter
  wire ext_fall = sck_d_reg & ~sck_s;
  wire ext_rise = ~sck_d_reg & sck_s;
  // internal divider tick, only while a transfer runs
  wire tick     = xfer & ~ext_clk & (div_reg == half - 8'h01);
  wire int_fall = tick & st_shift & sck_reg;
  wire int_rise = tick & st_shift & ~sck_reg;
  // shift events from whichever clock is selected
  wire fall_ev  = ext_clk ? (st_shift & ext_fall) : int_fall;
  wire rise_ev  = ext_clk ? (st_shift & ext_rise) : int_rise;
  // sequencing terms
  wire             abort_ev = xfer & cs_high;
  wire             start_ok = start_wr_in & ~busy & ~abort_reg;
  wire             stop_ev  = stop_wr_in & busy & ~abort_ev;
  wire             byte_end = rise_ev & (bit_reg == BIT_LAST);
  wire             last_hit = (idx_reg == last_idx_in);
  wire [IDX_W-1:0] idx_inc  = idx_reg + 5'h01;
  wire             done_ev  = byte_end & last_hit & ~abort_ev;
  wire             gap_go   = byte_end & ~last_hit & ~ext_clk
                              & (gap_len != GAP_ZERO);
  wire             gap_end  = st_gap & tick & (gap_reg == gap_len - 4'h1);
  wire [7:0]       rx_next  = {si_s, rx_reg[7:1]};
  // overrun: clock edges with nothing running, masked by chip-select
  wire ovr_ev  = ext_clk & ~busy & (ext_fall | ext_rise)
                 & ~cs_high;
  wire acc_ev  = (buf_rd_in | buf_wr_in) & busy;
  wire rx_wr   = byte_end & rx_en & ~abort_ev;
  wire cpu_wr  = buf_wr_in & ~busy;
  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          state_next = cs_en_in ? ST_WAIT : ST_SHIFT;
        end
      end
      ST_WAIT: begin
        if (stop_ev) begin
          state_next = ST_IDLE;
        end else if (!cs_s) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (abort_ev || stop_ev || done_ev) begin
          state_next = ST_IDLE;
        end else if (gap_go) begin
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (abort_ev || stop_ev) begin
          state_next = ST_IDLE;
        end else if (gap_end) begin
          state_next = ST_SHIFT;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // buffer index walks first..last, wrapping at the top
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_reg <= '0;
    end else if (start_ok) begin
      idx_reg <= first_idx_in;
    end else if (byte_end && !last_hit) begin
      idx_reg <= idx_inc;
    end
  end

  // bit counter, transmit byte and receive shifter; next byte read on the same edge
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_reg <= BIT_FIRST;
      sh_reg  <= '0;
      rx_reg  <= '0;
    end else if (start_ok) begin
      bit_reg <= BIT_FIRST;
      sh_reg  <= mem[first_idx_in];
    end else if (rise_ev) begin
      bit_reg <= bit_reg + 3'h1;
      rx_reg  <= rx_next;
      if (bit_reg == BIT_LAST) begin
        sh_reg <= mem[idx_inc];
      end
    end
  end

  // buffer array: serial write only while busy, cpu write only when idle
  always_ff @(posedge core_clk_in) begin
    if (rx_wr) begin
      mem[idx_reg] <= rx_next;
    end else if (cpu_wr) begin
      mem[buf_addr_in] <= buf_wdata_in;
    end
  end

  // cpu read data; busy reads return all ones
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= BUSY_READ;
    end else if (buf_rd_in) begin
      rdata_reg <= busy ? BUSY_READ : mem[buf_addr_in];
    end
  end

  // divider restarts each time a transfer or gap begins; gap counts half periods
  wire [7:0] div_next = (!xfer || ext_clk || tick) ? HALF_ZERO : div_reg + 8'h01;
  wire [3:0] gap_next = !st_gap ? GAP_ZERO : (tick ? gap_reg + 4'h1 : gap_reg);
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= HALF_ZERO;
      gap_reg <= GAP_ZERO;
    end else begin
      div_reg <= div_next;
      gap_reg <= gap_next;
    end
  end

  // serial clock: toggles in shift on the internal clock, parks high otherwise
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_reg <= SCK_IDLE;
    end else if (int_fall || int_rise) begin
      sck_reg <= ~sck_reg;
    end else if (!st_shift) begin
      sck_reg <= SCK_IDLE;
    end
  end

  // data output: level bit when idle, shifted data during a transfer with transmit enabled
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      so_reg <= SO_RESET;
    end else if (sol_wr_in && !busy) begin
      so_reg <= sol_val_in;
    end else if (fall_ev && tx_en) begin
      so_reg <= sh_reg[bit_reg];
    end
  end

  // sticky flags, a set in the clearing cycle wins; clock edge memory; strobe on internal clock
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_d_reg  <= SCK_IDLE;
      strobe_reg <= 1'b0;
      ovr_reg   <= 1'b0;
      wait_reg  <= 1'b0;
      abort_reg <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      sck_d_reg  <= sck_s;
      strobe_reg <= byte_end & strobe_en_in & ~ext_clk;
      ovr_reg   <= ovr_ev | (ovr_reg & ~ovr_clr_in);
      wait_reg  <= acc_ev | (wait_reg & ~wait_clr_in);
      abort_reg <= abort_ev | (abort_reg & ~abort_clr_in);
      irq_reg   <= done_ev | abort_ev | (irq_reg & ~irq_clr_in);
    end
  end

  // pins: abort floats clock and data until the flag is cleared
  assign sck_out        = sck_reg;
  assign sck_oe_out     = ~ext_clk & ~abort_reg;
  assign so_out         = open_drain_in ? 1'b0 : so_reg;
  assign so_oe_out      = tx_en & ~abort_reg
                          & (~open_drain_in | ~so_reg);
  assign strobe_out     = strobe_reg;
  assign buf_rdata_out  = rdata_reg;
  assign start_busy_out = busy;
  assign overrun_out    = ovr_reg;
  assign wait_out       = wait_reg;
  assign abort_out      = abort_reg;
  assign irq_req_out    = irq_reg;
  assign sol_out        = so_reg;

  // checks
  sequence s_last_byte;
    byte_end && last_hit && !abort_ev;
  endsequence
  property p_done;
    s_last_byte |=> !start_busy_out && irq_req_out;
  endproperty
  a_done: assert property (p_done) else $error("no finish");
  property p_abort;
    abort_ev |=> abort_out && !start_busy_out && !sck_oe_out && !so_oe_out;
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_no_start;
    abort_out && !abort_clr_in |=> !start_busy_out [*2];
  endproperty
  a_no_start: assert property (p_no_start) else $error("start in abort");
  property p_busy_read;
    buf_rd_in && start_busy_out |=> buf_rdata_out == BUSY_READ && wait_out;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read");
  property p_ovr;
    ovr_ev |=> overrun_out;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun");
  property p_sol;
    sol_wr_in && !start_busy_out |=> sol_out == $past(sol_val_in);
  endproperty
  a_sol: assert property (p_sol) else $error("level bit");
  property p_gap_high;
    st_gap |-> sck_out;
  endproperty
  a_gap_high: assert property (p_gap_high) else $error("gap clock");
  property p_idle_clk;
    !start_busy_out ##1 !start_busy_out |-> sck_out;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock");
  property p_go;
    start_ok && !cs_en_in |=> st_shift;
  endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_hold_w0;
    wait_out && !wait_clr_in |=> wait_out;
  endproperty
  a_hold_w0: assert property (p_hold_w0) else $error("flag lost");
  property p_tx_bit;
    fall_ev && tx_en |=> sol_out == $past(sh_reg[bit_reg]);
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("tx bit");

endmodule

/* File: pkg/bssp_pkg.sv */
// shared constants and types for the buffered synchronous serial port
package bssp_pkg;

  // buffer geometry
  localparam int          BUF_DEPTH = 32;
  localparam int          IDX_W     = 5;
  localparam int          BYTE_W    = 8;
  localparam logic [2:0]  BIT_FIRST = 3'h0;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic [7:0]  BUSY_READ = 8'hFF;

  // transfer direction bits of the mode field
  localparam int          MODE_TX_POS = 0;
  localparam int          MODE_RX_POS = 1;

  // clock select: codes 0 to 6 internal, code 6 at the rate of code 0; this code external
  localparam logic [2:0]  CKS_EXT = 3'h7;

  // reset levels
  localparam logic        SCK_IDLE  = 1'b1;
  localparam logic        SO_RESET  = 1'b0;
  localparam logic [7:0]  HALF_ZERO = 8'h00;
  localparam logic [3:0]  GAP_ZERO  = 4'h0;

  // half period of the internal serial clock in core cycles
  function automatic logic [7:0] bssp_half(input logic [2:0] sel);
    case (sel)
      3'h0:    bssp_half = 8'h80;
      3'h1:    bssp_half = 8'h20;
      3'h2:    bssp_half = 8'h10;
      3'h3:    bssp_half = 8'h08;
      3'h4:    bssp_half = 8'h04;
      3'h5:    bssp_half = 8'h02;
      default: bssp_half = 8'h80;
    endcase
  endfunction

  // gap length in serial half periods
  function automatic logic [3:0] bssp_gap(input logic [1:0] sel);
    case (sel)
      2'h1:    bssp_gap = 4'h2;
      2'h2:    bssp_gap = 4'h4;
      2'h3:    bssp_gap = 4'h8;
      default: bssp_gap = 4'h0;
    endcase
  endfunction

  // controller states, gray along idle-wait-shift-gap
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WAIT  = 2'h1,
    ST_SHIFT = 2'h3,
    ST_GAP   = 2'h2
  } bssp_state_e;

endpackage

/* File: hdl/bssp_sync3.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
module bssp_sync3 #(
  parameter logic INIT = 1'b1
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output wire logic q_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic q_reg;

  // first flop feeds only the second
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once second and third agree, rejects one-cycle glitches
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_reg <= INIT;
    end else if (s2_reg == s3_reg) begin
      q_reg <= s3_reg;
    end
  end

  assign q_out = q_reg;

endmodule

/* File: dv/bssp_peer.sv */
// behavioural serial peer: shifts bytes in and out and makes an external clock
`timescale 1ns/10ps
module bssp_peer (
  input  wire logic core_clk_in,
  input  wire logic sck_pin_in,
  input  wire logic so_pin_in,
  input  wire logic active_in,
  output logic      si_out,
  output logic      sck_drv_out
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [7:0] cur;
  logic [7:0] rx_sh;
  logic [2:0] tx_bit;
  logic [2:0] rx_bit;
  logic       sck_q;
  logic       act_q;

  // external clock idles high between bursts
  initial begin
    si_out = 1'b0;
    sck_drv_out = 1'b1;
    sck_q = 1'b1;
    act_q = 1'b0;
    tx_bit = 3'h0;
    rx_bit = 3'h0;
    cur = 8'h00;
    rx_sh = 8'h00;
  end

  // edges seen on the resolved pin; a released data line wanders every cycle
  always @(posedge core_clk_in) begin
    sck_q <= sck_pin_in;
    act_q <= active_in;
    if (!active_in && !act_q) begin
      si_out <= ~si_out;
      tx_bit <= 3'h0;
      rx_bit <= 3'h0;
    end else if (sck_q && !sck_pin_in) begin
      if (tx_bit == 3'h0) begin
        cur = (txq.size() > 0) ? txq.pop_front() : 8'h5A;
      end
      si_out <= cur[tx_bit];
      tx_bit <= tx_bit + 3'h1;
    end else if (!sck_q && sck_pin_in) begin
      rx_sh = {so_pin_in, rx_sh[7:1]};
      rx_bit <= rx_bit + 3'h1;
      if (rx_bit == 3'h7) begin
        rxq.push_back(rx_sh);
      end
    end
  end

  // clock burst; callers start it after start/busy is up, and also while idle to make stray clocks
  task automatic clocks(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge core_clk_in);
      sck_drv_out <= 1'b0;
      repeat (half) @(posedge core_clk_in);
      sck_drv_out <= 1'b1;
    end
  endtask
endmodule

/* File: dv/bssp_tb.sv */
// self-checking bench for the buffered synchronous serial port
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import bssp_pkg::*;
  logic       core_clk_in, rst_in, sol_val_in, buf_rd_in, buf_wr_in, cs_en_in, cs_n_in;
  logic       strobe_en_in, open_drain_in;
  logic [6:0] p;
  logic [4:0] buf_addr_in, first_idx_in, last_idx_in;
  logic [7:0] buf_wdata_in;
  logic [1:0] mode_in, gap_sel_in;
  logic [2:0] clk_sel_in;
  logic [7:0] halfs[6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
  wire logic  start_wr_in, stop_wr_in, ovr_clr_in, wait_clr_in, abort_clr_in, irq_clr_in;
  wire logic  sol_wr_in, start_busy_out, overrun_out, wait_out, abort_out, irq_req_out;
  wire logic  sol_out, sck_in, sck_out, sck_oe_out, si_in, so_out, so_oe_out, strobe_out;
  wire logic  peer_sck, so_pin;
  wire logic [7:0] buf_rdata_out;
  int         num_errors, num_checks, strobe_cnt, busy_cnt, n;
  int         gaps[4] = '{0, 2, 4, 8};
  localparam int PSTART = 0, PSTOP = 1, POCLR = 2, PWCLR = 3, PACLR = 4, PICLR = 5, PSOLW = 6;

  // one-cycle control pulses; released data pin pulled up, released clock pin driven by the peer
  assign {sol_wr_in, irq_clr_in, abort_clr_in, wait_clr_in, ovr_clr_in, stop_wr_in,
          start_wr_in} = p;
  assign sck_in = sck_oe_out ? sck_out : peer_sck;
  assign so_pin = so_oe_out ? so_out : 1'b1;

  bssp_core dut_u (.core_clk_in, .rst_in, .start_wr_in, .stop_wr_in, .ovr_clr_in,
    .wait_clr_in, .abort_clr_in, .irq_clr_in, .sol_wr_in, .sol_val_in, .buf_rd_in,
    .buf_wr_in, .buf_addr_in, .buf_wdata_in, .buf_rdata_out, .mode_in, .clk_sel_in,
    .gap_sel_in, .first_idx_in, .last_idx_in, .cs_en_in, .strobe_en_in, .open_drain_in,
    .start_busy_out, .overrun_out, .wait_out, .abort_out, .irq_req_out, .sol_out, .sck_in,
    .sck_out, .sck_oe_out, .si_in, .so_out, .so_oe_out, .cs_n_in, .strobe_out);
  bssp_peer peer_u (.core_clk_in(core_clk_in), .sck_pin_in(sck_in), .so_pin_in(so_pin),
    .active_in(start_busy_out), .si_out(si_in), .sck_drv_out(peer_sck));

  // 200 MHz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // strobe pulses and busy cycles counted per transfer
  always @(posedge core_clk_in) begin
    if (strobe_out === 1'b1) strobe_cnt <= strobe_cnt + 1;
    if (start_busy_out === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  function automatic logic [7:0] pat(input logic [4:0] i);
    return {3'h0, i} * 8'h1D + 8'h03;
  endfunction

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk_in) p[i] <= 1'b1;
    @(posedge core_clk_in) p[i] <= 1'b0;
  endtask

  task automatic bwr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    buf_wr_in <= 1'b1;
    buf_addr_in <= a;
    buf_wdata_in <= d;
    @(posedge core_clk_in) buf_wr_in <= 1'b0;
  endtask

  task automatic brd(input logic [4:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    buf_rd_in <= 1'b1;
    buf_addr_in <= a;
    @(posedge core_clk_in) buf_rd_in <= 1'b0;
    @(negedge core_clk_in) `CHK(buf_rdata_out, e)
  endtask

  // configuration changes only between transfers
  task automatic cfg(input logic [1:0] m, input logic [2:0] s, input logic [1:0] g,
                     input logic [4:0] f, input logic [4:0] l);
    @(posedge core_clk_in);
    mode_in <= m;
    clk_sel_in <= s;
    gap_sel_in <= g;
    first_idx_in <= f;
    last_idx_in <= l;
  endtask

  // bounded wait for the end of a transfer, then acknowledge it
  task automatic wait_done;
    int k;
    k = 0;
    do begin
      @(negedge core_clk_in);
      k++;
    end while (start_busy_out !== 1'b0 && k < 9000);
    `CHK(start_busy_out, 1'b0)
    `CHK(irq_req_out, 1'b1)
    pulse(PICLR);
  endtask

  task automatic run;
    pulse(PSTART);
    wait_done();
  endtask

  task automatic rx_chk(input logic [7:0] e);
    logic [7:0] g;
    g = (peer_u.rxq.size() > 0) ? peer_u.rxq.pop_front() : 8'hXX;
    `CHK(g, e)
  endtask

  task automatic quiet(input int c);
    n = 0;
    repeat (c) begin
      @(negedge core_clk_in);
      if (sck_out !== 1'b1) n++;
    end
  endtask

  // hang guard, well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge core_clk_in);
    num_errors++;
    finish_test();
  end

  initial begin
    {p, sol_val_in, buf_rd_in, buf_wr_in, cs_en_in, strobe_en_in, open_drain_in} = '0;
    {buf_addr_in, first_idx_in, last_idx_in, buf_wdata_in, gap_sel_in, clk_sel_in} = '0;
    mode_in = 2'h1;
    cs_n_in = 1'b1;
    num_errors = 0;
    num_checks = 0;
    strobe_cnt = 0;
    busy_cnt = 0;
    rst_in = 1'b1;
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(negedge core_clk_in);
    `CHK({start_busy_out, overrun_out, wait_out, abort_out, irq_req_out, sol_out}, 6'h00)
    `CHK({sck_out, strobe_out, buf_rdata_out}, 10'h2FF)
    for (int i = 0; i < 32; i++) bwr(i[4:0], pat(i[4:0]));
    brd(5'h1F, pat(5'h1F));
    // idle level writes, push-pull and open-drain
    @(posedge core_clk_in) sol_val_in <= 1'b1;
    pulse(PSOLW);
    @(negedge core_clk_in) `CHK({sol_out, so_out, so_oe_out}, 3'h7)
    @(posedge core_clk_in) open_drain_in <= 1'b1;
    @(negedge core_clk_in) `CHK({so_out, so_oe_out}, 2'h0)
    @(posedge core_clk_in) sol_val_in <= 1'b0;
    pulse(PSOLW);
    @(negedge core_clk_in) `CHK({so_out, so_oe_out}, 2'h1)
    @(posedge core_clk_in) open_drain_in <= 1'b0;
    sol_val_in <= 1'b1;
    pulse(PSOLW);
    // every internal rate, one byte each; so ends at bit 7 of 8'h03
    for (int s = 0; s < 6; s++) begin
      peer_u.rxq.delete();
      cfg(2'h1, s[2:0], 2'h0, 5'h00, 5'h00);
      pulse(PSTART);
      n = 0;
      while (sck_out !== 1'b0 && n < 600) begin @(negedge core_clk_in); n++; end
      n = 0;
      while (sck_out === 1'b0 && n < 600) begin @(negedge core_clk_in); n++; end
      `CHK(n[7:0], halfs[s])
      `CHK(sck_oe_out, 1'b1)
      wait_done();
      rx_chk(pat(5'h00));
      `CHK({sol_out, so_out}, 2'h0)
    end
    quiet(40);
    `CHK(n, 0)
    cfg(2'h0, 3'h5, 2'h0, 5'h04, 5'h04);
    run();
    // wrapped block, every gap code, buffer locked while busy
    @(posedge core_clk_in) strobe_en_in <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      peer_u.rxq.delete();
      cfg(2'h1, 3'h5, g[1:0], 5'h1E, 5'h01);
      strobe_cnt = 0;
      busy_cnt = 0;
      pulse(PSTART);
      brd(5'h03, 8'hFF);
      bwr(5'h03, 8'h00);
      @(negedge core_clk_in) `CHK(wait_out, 1'b1)
      pulse(PWCLR);
      wait_done();
      `CHK(wait_out, 1'b0)
      `CHK(strobe_cnt, 4)
      `CHK(busy_cnt, (64 + 3 * gaps[g]) * halfs[5])
      for (int k = 0; k < 4; k++) rx_chk(pat(5'h1E + k[4:0]));
    end
    brd(5'h03, pat(5'h03));
    // combined single byte
    peer_u.rxq.delete();
    peer_u.txq.push_back(8'h3C);
    cfg(2'h3, 3'h3, 2'h0, 5'h0C, 5'h0C);
    run();
    brd(5'h0C, 8'h3C);
    rx_chk(pat(5'h0C));
    // external clock receive, then stray clocks
    peer_u.txq.push_back(8'hA7);
    cfg(2'h2, CKS_EXT, 2'h0, 5'h0A, 5'h0A);
    pulse(PSTART);
    `CHK(sck_oe_out, 1'b0)
    peer_u.clocks(8, 16);
    wait_done();
    brd(5'h0A, 8'hA7);
    peer_u.clocks(2, 16);
    repeat (6) @(negedge core_clk_in);
    `CHK(overrun_out, 1'b1)
    brd(5'h0A, 8'hA7);
    pulse(POCLR);
    @(negedge core_clk_in) `CHK(overrun_out, 1'b0)
    @(posedge core_clk_in) cs_en_in <= 1'b1;
    peer_u.clocks(2, 16);
    repeat (6) @(negedge core_clk_in);
    `CHK(overrun_out, 1'b0)
    // chip-select wait, stop, abort and refused start
    cfg(2'h1, 3'h3, 2'h0, 5'h02, 5'h03);
    pulse(PSTART);
    quiet(40);
    `CHK({n[7:0], start_busy_out}, 9'h001)
    bwr(5'h02, 8'h00);
    @(negedge core_clk_in) `CHK(wait_out, 1'b1)
    pulse(PWCLR);
    pulse(PSTOP);
    @(negedge core_clk_in) `CHK({start_busy_out, irq_req_out}, 2'h0)
    pulse(PSTART);
    @(posedge core_clk_in) cs_n_in <= 1'b0;
    n = 0;
    while (sck_out !== 1'b0 && n < 100) begin @(negedge core_clk_in); n++; end
    repeat (20) @(posedge core_clk_in);
    cs_n_in <= 1'b1;
    repeat (8) @(negedge core_clk_in);
    `CHK({start_busy_out, abort_out, irq_req_out, sck_oe_out, so_oe_out}, 5'h0C)
    pulse(PICLR);
    pulse(PSTART);
    repeat (2) @(negedge core_clk_in);
    `CHK(start_busy_out, 1'b0)
    pulse(PACLR);
    @(posedge core_clk_in) cs_n_in <= 1'b0;
    peer_u.rxq.delete();
    run();
    rx_chk(pat(5'h02));
    rx_chk(pat(5'h03));
    finish_test();
  end
endmodule
